// >>> inc/embp_pkg.sv
package embp_pkg;
   // Address decode windows (24-bit CPU byte address)
   localparam logic [23:0] BOOT_LO  = 24'h000000;
   localparam logic [23:0] BOOT_HI  = 24'h03FFFF;
   localparam logic [23:0] BANK1_LO = 24'h800000;
   localparam logic [23:0] BANK1_HI = 24'h83FFFF;
   localparam logic [23:0] BANK2_LO = 24'hC00000;
   localparam logic [23:0] BANK2_HI = 24'hC3FFFF;
   // Boot mode pin codes
   localparam logic [1:0]  MODE_INT_FLASH = 2'h0;
   localparam logic [1:0]  MODE_EXT_ROM   = 2'h1;
   localparam logic [1:0]  MODE_MDS       = 2'h2;
   // Widths and wait range
   localparam int          ADDR_W     = 24;
   localparam int          PIN_ADDR_W = 18;
   localparam int          DED_ADDR_W = 12;
   localparam logic [2:0]  WAIT_MAX   = 3'h7;
   localparam logic [2:0]  WAIT_RST   = 3'h7;
   // Hold phase cycles before pin samples are trusted (two-flop lag)
   localparam logic [1:0]  SETTLE_CYC = 2'h2;

   // CPU-side request
   typedef struct packed {
      logic [23:0] addr;
      logic        write;
      logic [7:0]  wdata;
   } embp_req_s;

   // Decoded bank selects, active high internally
   typedef struct packed {
      logic boot;
      logic bank1;
      logic bank2;
   } embp_sel_s;
endpackage

// >>> logic/embp_decode.sv
`timescale 1ns/1ns
// Bank address decoder, purely combinational
module embp_decode (
   input  wire logic [23:0]        addr_in,
   input  wire logic [1:0]         boot_mode_in,
   output embp_pkg::embp_sel_s     sel_out
);
   logic ext_boot;

   // Boot bank only reaches the pins when the straps pick external ROM or MDS
   assign ext_boot = (boot_mode_in == embp_pkg::MODE_EXT_ROM) ||
                     (boot_mode_in == embp_pkg::MODE_MDS);

   // Windows never overlap, so one select at most is set
   always_comb begin
      sel_out.boot  = ext_boot && (addr_in <= embp_pkg::BOOT_HI);
      sel_out.bank1 = (addr_in >= embp_pkg::BANK1_LO) &&
                      (addr_in <= embp_pkg::BANK1_HI);
      sel_out.bank2 = (addr_in >= embp_pkg::BANK2_LO) &&
                      (addr_in <= embp_pkg::BANK2_HI);
   end
endmodule

// >>> logic/embp_port.sv
`timescale 1ns/1ns
// Function
// - Boot bank select asserts only for addresses 0x0..0x3FFFF in external ROM or MDS mode.
// - Bank 1 select asserts for addresses 0x800000..0x83FFFF.
// - Bank 2 select asserts for addresses 0xC00000..0xC3FFFF.
// - While bus hold is low the open cycle is stretched and does not complete.
// - Read strobe is asserted low during a read cycle.
// - Write strobe is asserted low during a write cycle.
// - The port drives data during writes and samples the external data during reads.
// - Address bits 11..0 are dedicated; bits 17..12 go out only when the pin mux picks them.
// - Boot mode 00 boots internally, 01 routes boot fetches through the boot bank.
// - Each access gets a programmable 0 to 7 wait cycles.
module embp_port (
   input  wire logic                clk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                req_valid_in,
   input  embp_pkg::embp_req_s      req_in,
   input  wire logic [2:0]          wait_cycles_in,
   input  wire logic [5:0]          addr_hi_pin_en_in,
   input  wire logic [1:0]          boot_mode_pins_in,
   input  wire logic                bus_hold_n_in,
   input  wire logic [7:0]          data_pin_in,
   output logic                     req_ready_out,
   output logic                     done_out,
   output logic                     unmapped_out,
   output logic [7:0]               rdata_out,
   output logic [17:0]              addr_out,
   output logic [5:0]               addr_hi_oe_out,
   output logic                     boot_bank_select_n_out,
   output logic                     bank1_select_n_out,
   output logic                     bank2_select_n_out,
   output logic                     read_strobe_n_out,
   output logic                     write_strobe_n_out,
   output logic [7:0]               data_pin_out,
   output logic                     data_pin_oe_out
);
   typedef enum logic [2:0] {
      EMBP_IDLE   = 3'b001,
      EMBP_ACCESS = 3'b010,
      EMBP_HOLD   = 3'b100
   } embp_state_e;

   embp_state_e          state;
   embp_state_e          next_state;
   logic [2:0]           wait_cnt;
   logic [2:0]           next_wait_cnt;
   logic [1:0]           settle_cnt;
   logic [1:0]           next_settle_cnt;
   logic                 is_write;
   logic                 next_is_write;
   logic [7:0]           rdata;
   logic [7:0]           next_rdata;
   logic [17:0]          addr;
   logic [17:0]          next_addr;
   logic [7:0]           wdata;
   logic [7:0]           next_wdata;
   embp_pkg::embp_sel_s  sel;
   embp_pkg::embp_sel_s  next_sel;
   embp_pkg::embp_sel_s  dec_sel;
   logic                 done;
   logic                 next_done;
   logic                 unmapped;
   logic                 next_unmapped;
   logic                 hold_meta;
   logic                 hold_sync;
   logic [7:0]           data_meta;
   logic [7:0]           data_sync;
   logic [1:0]           mode_meta;
   logic [1:0]           mode_sync;

   embp_decode u_decode (
      .addr_in      (req_in.addr),
      .boot_mode_in (mode_sync),
      .sel_out      (dec_sel)
   );

   // Pin inputs cross two flops; the first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hold_meta <= 1'b1;
         hold_sync <= 1'b1;
         data_meta <= 8'h00;
         data_sync <= 8'h00;
         mode_meta <= 2'h0;
         mode_sync <= 2'h0;
      end else begin
         hold_meta <= bus_hold_n_in;
         hold_sync <= hold_meta;
         data_meta <= data_pin_in;
         data_sync <= data_meta;
         mode_meta <= boot_mode_pins_in;
         mode_sync <= mode_meta;
      end
   end

   assign req_ready_out = (state == EMBP_IDLE);

   // Cycle sequencer: access phase counts waits, then a hold phase honours bus hold
   always_comb begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      next_settle_cnt = settle_cnt;
      next_is_write = is_write;
      next_rdata    = rdata;
      next_addr     = addr;
      next_wdata    = wdata;
      next_sel      = sel;
      next_done     = 1'b0;
      next_unmapped = 1'b0;
      unique case (state)
         EMBP_IDLE: begin
            if (req_valid_in) begin
               if (dec_sel == '0) begin
                  next_done     = 1'b1; // Outside every window: no pin activity
                  next_unmapped = 1'b1;
               end else begin
                  next_sel      = dec_sel;
                  next_is_write = req_in.write;
                  next_addr     = req_in.addr[17:0];
                  next_wdata    = req_in.wdata;
                  next_wait_cnt = (wait_cycles_in > embp_pkg::WAIT_MAX) ?
                                  embp_pkg::WAIT_MAX : wait_cycles_in;
                  next_state    = EMBP_ACCESS;
               end
            end
         end
         EMBP_ACCESS: begin
            if (wait_cnt == 3'h0) begin
               next_state      = EMBP_HOLD;
               next_settle_cnt = embp_pkg::SETTLE_CYC;
            end else begin
               next_wait_cnt = wait_cnt - 3'h1;
            end
         end
         EMBP_HOLD: begin
            // Pin samples lag two edges; without this wait a short access would
            // miss a hold and latch data from before the strobe fell
            if (settle_cnt != 2'h0) begin
               next_settle_cnt = settle_cnt - 2'h1;
            end else if (hold_sync) begin
               if (!is_write) begin
                  next_rdata = data_sync;
               end
               next_sel   = '0;
               next_done  = 1'b1;
               next_state = EMBP_IDLE;
            end
         end
         default: begin
            next_state = EMBP_IDLE;
            next_sel   = '0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state    <= EMBP_IDLE;
         wait_cnt <= 3'h0;
         settle_cnt <= 2'h0;
         is_write <= 1'b0;
         rdata    <= 8'h00;
         addr     <= 18'h00000;
         wdata    <= 8'h00;
         sel      <= '0;
         done     <= 1'b0;
         unmapped <= 1'b0;
      end else begin
         state    <= next_state;
         wait_cnt <= next_wait_cnt;
         settle_cnt <= next_settle_cnt;
         is_write <= next_is_write;
         rdata    <= next_rdata;
         addr     <= next_addr;
         wdata    <= next_wdata;
         sel      <= next_sel;
         done     <= next_done;
         unmapped <= next_unmapped;
      end
   end

   // Pin drive: strobes and selects follow the registered cycle state
   always_comb begin
      boot_bank_select_n_out = ~sel.boot;
      bank1_select_n_out     = ~sel.bank1;
      bank2_select_n_out     = ~sel.bank2;
      read_strobe_n_out      = ~((state != EMBP_IDLE) && !is_write);
      write_strobe_n_out     = ~((state != EMBP_IDLE) && is_write);
      data_pin_oe_out        = (state != EMBP_IDLE) && is_write;
      data_pin_out           = wdata;
      addr_out               = addr;
      addr_hi_oe_out         = addr_hi_pin_en_in;
      done_out               = done;
      unmapped_out           = unmapped;
      rdata_out              = rdata;
   end

   sequence s_access_start;
      (state == EMBP_IDLE) && (next_state == EMBP_ACCESS);
   endsequence

   AST_ONE_SELECT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $onehot0({boot_bank_select_n_out, bank1_select_n_out, bank2_select_n_out} ^ 3'h7))
      else $error("more than one bank select active");
   AST_BOOT_WINDOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      s_access_start |=> (!boot_bank_select_n_out == ((mode_sync == embp_pkg::MODE_EXT_ROM
         || mode_sync == embp_pkg::MODE_MDS) && ($past(req_in.addr) <= embp_pkg::BOOT_HI))))
      else $error("boot select mismatch");
   AST_BANK1_WINDOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      s_access_start |=> (!bank1_select_n_out == ($past(req_in.addr) >= embp_pkg::BANK1_LO
         && $past(req_in.addr) <= embp_pkg::BANK1_HI)))
      else $error("bank1 select mismatch");
   AST_BANK2_WINDOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      s_access_start |=> (!bank2_select_n_out == ($past(req_in.addr) >= embp_pkg::BANK2_LO
         && $past(req_in.addr) <= embp_pkg::BANK2_HI)))
      else $error("bank2 select mismatch");
   AST_HOLD_STRETCH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state == EMBP_HOLD && !hold_sync) |=> (state == EMBP_HOLD) && !done)
      else $error("cycle ended while bus hold low");
   AST_READ_STROBE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state != EMBP_IDLE && !is_write) |-> !read_strobe_n_out && write_strobe_n_out)
      else $error("read strobe wrong");
   AST_WRITE_STROBE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state != EMBP_IDLE && is_write) |-> !write_strobe_n_out && data_pin_oe_out)
      else $error("write strobe wrong");
   AST_READ_SAMPLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state == EMBP_HOLD && settle_cnt == 2'h0 && hold_sync && !is_write)
         |=> done && rdata_out == $past(data_sync))
      else $error("read data not captured");
   AST_SETTLE_WAIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state == EMBP_HOLD && settle_cnt != 2'h0) |=> (state == EMBP_HOLD) && !done)
      else $error("cycle ended before pin samples settled");
   AST_WAIT_COUNT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      s_access_start ##1 (wait_cnt == 3'h0) |=> (state == EMBP_HOLD))
      else $error("zero wait access did not advance");
   AST_BUS_RELEASE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !(state != EMBP_IDLE && is_write) |-> !data_pin_oe_out
         && !(!read_strobe_n_out && !write_strobe_n_out))
      else $error("data bus driven outside write");
endmodule

// >>> tb/embp_mem_model.sv
`timescale 1ns/1ns
// Byte memory behind the port; drives data only while selected and read
module embp_mem_model (
   input  wire logic        clk_in,
   input  wire logic        sel_n_in,
   input  wire logic        read_strobe_n_in,
   input  wire logic        write_strobe_n_in,
   input  wire logic [17:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wdata_oe_in,
   input  wire logic [3:0]  hold_len_in,
   output logic             bus_hold_n_out,
   output logic [7:0]       data_out
);
   logic [7:0] mem [256];
   logic [3:0] hold_cnt = 4'h0;
   logic       idle_d = 1'b1;
   // Known contents, so reads of untouched bytes never hand back unknowns
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
      end
   end
   // Released bus falls to the pull-down level, never the last byte
   assign data_out = (!sel_n_in && !read_strobe_n_in) ? mem[addr_in[7:0]] : 8'h00;
   assign bus_hold_n_out = (hold_cnt == 4'h0);
   // Hold starts when a strobe falls, so a slow device stalls every cycle
   always @(posedge clk_in) begin
      idle_d <= read_strobe_n_in & write_strobe_n_in;
      if (idle_d && !(read_strobe_n_in & write_strobe_n_in)) begin
         hold_cnt <= hold_len_in;
      end else if (hold_cnt != 4'h0) begin
         hold_cnt <= hold_cnt - 4'h1;
      end
      if (!sel_n_in && !write_strobe_n_in && wdata_oe_in) begin
         mem[addr_in[7:0]] <= wdata_in;
      end
   end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
// Port bench; inputs change on the falling edge only
module testbench;
   logic                clk_in, sys_rst_in, req_valid_in, hold_n, ready, done, unm, unm_seen;
   embp_pkg::embp_req_s req;
   logic [2:0]          wt, sel_seen;
   logic [1:0]          mode, strb;
   logic [3:0]          hold_len;
   logic [7:0]          rdata, pin_out, mem_data, data_wire;
   logic [17:0]         addr, addr_seen;
   logic [5:0]          hi_oe, hi_en;
   logic                cs0_n, cs1_n, cs2_n, rd_n, wr_n, oe;
   int                  errors, checks_done, lat, bad;
   // Wire level of the shared data pins
   assign data_wire = oe ? pin_out : mem_data;
   embp_port uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
      .req_in(req), .wait_cycles_in(wt), .addr_hi_pin_en_in(hi_en), .boot_mode_pins_in(mode),
      .bus_hold_n_in(hold_n), .data_pin_in(data_wire), .req_ready_out(ready), .done_out(done),
      .unmapped_out(unm), .rdata_out(rdata), .addr_out(addr), .addr_hi_oe_out(hi_oe),
      .boot_bank_select_n_out(cs0_n), .bank1_select_n_out(cs1_n), .bank2_select_n_out(cs2_n),
      .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .data_pin_out(pin_out),
      .data_pin_oe_out(oe));
   embp_mem_model mem (.clk_in(clk_in), .sel_n_in(cs0_n & cs1_n & cs2_n),
      .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .addr_in(addr), .wdata_in(pin_out),
      .wdata_oe_in(oe), .hold_len_in(hold_len), .bus_hold_n_out(hold_n), .data_out(mem_data));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   task automatic summarize;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One request; records latency, selects and strobes seen on the bus
   task automatic access(input logic [23:0] a, input logic w, input logic [7:0] d,
                         input logic [2:0] wc);
      req_valid_in = 1'b1;
      req = '{a, w, d};
      wt = wc;
      lat = 0;
      sel_seen = 3'h0;
      strb = 2'h0;
      @(negedge clk_in);
      req_valid_in = 1'b0;
      while (done !== 1'b1 && lat < 200) begin
         lat++;
         if (oe === 1'b1 && wr_n !== 1'b0) bad++;
         if ($countones({!cs0_n, !cs1_n, !cs2_n, !rd_n && !wr_n}) > 1) bad++;
         sel_seen |= {!cs0_n, !cs1_n, !cs2_n};
         strb |= {!rd_n, !wr_n};
         if (!(cs0_n && cs1_n && cs2_n)) addr_seen = addr;
         @(negedge clk_in);
      end
      unm_seen = unm;
      // An unmapped request ends at once; one more edge keeps valid from
      // being dropped and raised again in the same time step
      if (lat == 0) @(negedge clk_in);
   endtask
   task automatic t_reset;
      chk({cs0_n, cs1_n, cs2_n, rd_n, wr_n, oe, ready, done}, 8'hFA);
      chk(hi_oe, 6'h2A);
      hi_en = 6'h15;
      @(negedge clk_in);
      chk(hi_oe, 6'h15);
      repeat (4) @(negedge clk_in);
   endtask
   task automatic t_decode;
      logic [23:0] a [11] = '{24'h000000, 24'h03FFFF, 24'h040000, 24'h7FFFFF, 24'h800000,
         24'h83FFFF, 24'h840000, 24'hC00000, 24'hC3FFFF, 24'hC40000, 24'hFFFFFF};
      logic [2:0] s [11] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0};
      for (int i = 0; i < 11; i++) begin
         access(a[i], 1'b0, 8'h00, 3'h0);
         chk(sel_seen, s[i]);
         chk(unm_seen, s[i] == 3'h0);
         if (s[i] != 3'h0) chk(addr_seen, a[i][17:0]);
         if (s[i] == 3'h0) chk(lat, 0);
      end
   endtask
   task automatic t_mode;
      for (int m = 0; m < 4; m++) begin
         mode = m[1:0];
         repeat (4) @(negedge clk_in);
         access(24'h000100, 1'b0, 8'h00, 3'h1);
         chk(sel_seen, (m == 1 || m == 2) ? 3'h4 : 3'h0);
      end
      mode = 2'h1;
      repeat (4) @(negedge clk_in);
   endtask
   task automatic t_data;
      access(24'h800012, 1'b1, 8'hA5, 3'h2);
      chk(strb, 2'h1);
      access(24'hC3FFFF, 1'b1, 8'h3C, 3'h0);
      access(24'h800012, 1'b0, 8'h00, 3'h3);
      chk(strb, 2'h2);
      chk(rdata, 8'hA5);
      access(24'hC3FFFF, 1'b0, 8'h00, 3'h3);
      chk(rdata, 8'h3C);
   endtask
   task automatic t_timing;
      int l0;
      access(24'h800000, 1'b0, 8'h00, 3'h0);
      l0 = lat;
      access(24'h800000, 1'b0, 8'h00, 3'h7);
      chk(lat - l0, 7);
      hold_len = 4'h6;
      access(24'hC00000, 1'b0, 8'h00, 3'h0);
      chk(lat >= l0 + 5 && lat <= l0 + 8, 1);
      hold_len = 4'h0;
   endtask
   // Runaway guard well above the 150 or so cycles the scenarios need
   initial begin
      #100000;
      errors++;
      summarize;
   end
   initial begin
      sys_rst_in = 1'b1;
      req_valid_in = 1'b0;
      req = '0;
      wt = 3'h0;
      mode = 2'h1;
      hold_len = 4'h0;
      hi_en = 6'h2A;
      errors = 0;
      checks_done = 0;
      bad = 0;
      repeat (6) @(negedge clk_in);
      sys_rst_in = 1'b0;
      t_reset;
      t_decode;
      t_mode;
      t_data;
      t_timing;
      chk(bad, 0);
      summarize;
   end
endmodule
